// ---- rtl/haptic_closed_loop_cal_regs.sv ----
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "haptic_cal_map.svh"
module haptic_closed_loop_cal_regs (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         reset_n_i,
   // Register port
   input  wire logic [7:0]                   addr_i,
   input  wire logic [7:0]                   wdata_i,
   input  wire logic                         wr_i,
   input  wire logic                         rd_i,
   output logic [7:0]                        rdata_o,
   // Calibration result port
   input  wire logic                         cal_done_i,
   input  wire logic [7:0]                   cal_comp_i,
   input  wire logic [1:0]                   cal_amp_gain_i,
   // Playback engine request
   input  wire haptic_cal_pkg::drive_phase_t phase_i,
   input  wire logic [7:0]                   req_mag_i,
   // Drive outputs
   output logic [7:0]                        level_o,
   output logic [11:0]                       fb_gain_o,
   output haptic_cal_pkg::loop_speed_t       loop_speed_o,
   output logic [1:0]                        amp_gain_o,
   output logic [7:0]                        loss_comp_o
);
   import haptic_cal_pkg::*;

   // Register storage, one byte per offset of the bank
   logic [7:0] fs_q, fs_d;          // Full-scale reference
   logic [7:0] clamp_q, clamp_d;    // Overdrive clamp level
   logic [7:0] comp_q, comp_d;      // Loss compensation result
   logic [7:0] fbcal_q, fbcal_d;    // Feedback gain calibration
   logic [7:0] ctrl_q, ctrl_d;      // Feedback loop control
   logic [7:0] rdata_d;             // Next read data

   // The shaper sees the stored bytes directly, so a write acts on its next sample
   shaper_cfg_if cfg_bus ();        // Link to the shaper

   // Address match helper
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      // Exact compare, so the bank never aliases elsewhere in the address space
      hit = (a == ofs);
   endfunction

   // Host writes, then calibration writeback on top of them
   always_comb begin
      fs_d    = fs_q;
      clamp_d = clamp_q;
      comp_d  = comp_q;
      fbcal_d = fbcal_q;
      ctrl_d  = ctrl_q;
      // Writes outside the bank match nothing and are dropped
      if (wr_i) begin
         if (hit(addr_i, `FULL_SCALE_REFERENCE_OFS))      fs_d    = wdata_i;
         if (hit(addr_i, `OVERDRIVE_CLAMP_LEVEL_OFS))     clamp_d = wdata_i;
         if (hit(addr_i, `LOSS_COMPENSATION_RESULT_OFS))  comp_d  = wdata_i;
         if (hit(addr_i, `FEEDBACK_GAIN_CALIBRATION_OFS)) fbcal_d = wdata_i;
         if (hit(addr_i, `FEEDBACK_LOOP_CONTROL_OFS))     ctrl_d  = wdata_i;
      end
      // Calibration wins a same-cycle collision so a result is never lost
      // Only the amplifier-gain bits of the control byte are touched here
      if (cal_done_i) begin
         comp_d                             = cal_comp_i;
         ctrl_d[`AMP_GAIN_MSB:`AMP_GAIN_LSB] = cal_amp_gain_i;
      end
   end

   // Read mux; unmapped addresses read zero
   // Data is registered so it stands for exactly the cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (rd_i) begin
         if (hit(addr_i, `FULL_SCALE_REFERENCE_OFS))      rdata_d = fs_q;
         if (hit(addr_i, `OVERDRIVE_CLAMP_LEVEL_OFS))     rdata_d = clamp_q;
         if (hit(addr_i, `LOSS_COMPENSATION_RESULT_OFS))  rdata_d = comp_q;
         if (hit(addr_i, `FEEDBACK_GAIN_CALIBRATION_OFS)) rdata_d = fbcal_q;
         if (hit(addr_i, `FEEDBACK_LOOP_CONTROL_OFS))     rdata_d = ctrl_q;
      end
   end

   // Register storage with documented defaults
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fs_q    <= `FULL_SCALE_REFERENCE_RST;
         // Clamp starts at the top code, so overdrive is unlimited until set
         clamp_q <= `OVERDRIVE_CLAMP_LEVEL_RST;
         comp_q  <= `LOSS_COMPENSATION_RESULT_RST;
         fbcal_q <= `FEEDBACK_GAIN_CALIBRATION_RST;
         ctrl_q  <= `FEEDBACK_LOOP_CONTROL_RST;
         rdata_o <= 8'h00;
      end else begin
         fs_q    <= fs_d;
         clamp_q <= clamp_d;
         comp_q  <= comp_d;
         fbcal_q <= fbcal_d;
         ctrl_q  <= ctrl_d;
         rdata_o <= rdata_d;
      end
   end

   // Configuration to the shaper
   assign cfg_bus.full_scale = fs_q;
   assign cfg_bus.clamp      = clamp_q;
   assign cfg_bus.fb_cal     = fbcal_q;
   assign cfg_bus.ctrl       = loop_ctrl_t'(ctrl_q);

   // Analog settings straight from the registers
   // They leave the block raw; the analog stage applies its own scaling
   assign amp_gain_o  = ctrl_q[`AMP_GAIN_MSB:`AMP_GAIN_LSB];
   assign loss_comp_o = comp_q;

   drive_shaper u_shaper (
      .clk_i        (clk_i),
      .reset_n_i    (reset_n_i),
      .cfg          (cfg_bus.shaper),
      .phase_i      (phase_i),
      .req_mag_i    (req_mag_i),
      .level_o      (level_o),
      .fb_gain_o    (fb_gain_o),
      .loop_speed_o (loop_speed_o)
   );

   // Calibration result lands in the compensation register
   a_cal_comp_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cal_done_i |=> comp_q == $past(cal_comp_i))
      else $error("Compensation result not stored");
   // Calibration result lands in the amplifier-gain bits
   a_cal_amp_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cal_done_i |=> ctrl_q[1:0] == $past(cal_amp_gain_i))
      else $error("Amplifier gain not overwritten");
   // Calibration leaves the rest of the control byte alone
   a_cal_ctrl_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cal_done_i && !(wr_i && addr_i == `FEEDBACK_LOOP_CONTROL_OFS))
      |=> ctrl_q[7:2] == $past(ctrl_q[7:2]))
      else $error("Calibration disturbed control fields");
   // Host bits above the gain field survive a collision with calibration
   a_ctrl_upper_cal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (cal_done_i && wr_i && addr_i == `FEEDBACK_LOOP_CONTROL_OFS)
      |=> ctrl_q[7:2] == $past(wdata_i[7:2]))
      else $error("Host control bits lost to calibration");
   // A full-scale write still holds a cycle later when nothing rewrites it
   a_write_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == `FULL_SCALE_REFERENCE_OFS) ##1 !(wr_i && addr_i == `FULL_SCALE_REFERENCE_OFS)
      |=> fs_q == $past(wdata_i, 2))
      else $error("Full-scale write not held");
   // Control read returns the stored byte
   a_read_back: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `FEEDBACK_LOOP_CONTROL_OFS) |=> rdata_o == $past(ctrl_q))
      else $error("Control read data wrong");

   // Host write to the full-scale reference lands at its strobe edge
   a_fs_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == `FULL_SCALE_REFERENCE_OFS) |=> fs_q == $past(wdata_i))
      else $error("Full-scale write lost");
   // Host write to the clamp lands at its strobe edge
   a_clamp_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == `OVERDRIVE_CLAMP_LEVEL_OFS) |=> clamp_q == $past(wdata_i))
      else $error("Clamp write lost");
   // Host write to the compensation register lands when calibration is quiet
   a_comp_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == `LOSS_COMPENSATION_RESULT_OFS && !cal_done_i)
      |=> comp_q == $past(wdata_i))
      else $error("Compensation write lost");
   // Host write to the feedback calibration lands at its strobe edge
   a_fbcal_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == `FEEDBACK_GAIN_CALIBRATION_OFS) |=> fbcal_q == $past(wdata_i))
      else $error("Feedback calibration write lost");
   // Host write to the control byte lands when calibration is quiet
   a_ctrl_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == `FEEDBACK_LOOP_CONTROL_OFS && !cal_done_i)
      |=> ctrl_q == $past(wdata_i))
      else $error("Control write lost");

   // Full-scale reference moves only on its own write
   a_fs_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == `FULL_SCALE_REFERENCE_OFS) |=> $stable(fs_q))
      else $error("Full-scale changed without a write");
   // Clamp moves only on its own write
   a_clamp_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == `OVERDRIVE_CLAMP_LEVEL_OFS) |=> $stable(clamp_q))
      else $error("Clamp changed without a write");
   // Compensation moves only on its own write or on calibration
   a_comp_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!(wr_i && addr_i == `LOSS_COMPENSATION_RESULT_OFS) && !cal_done_i)
      |=> $stable(comp_q))
      else $error("Compensation changed without a write");
   // Feedback calibration moves only on its own write
   a_fbcal_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == `FEEDBACK_GAIN_CALIBRATION_OFS) |=> $stable(fbcal_q))
      else $error("Feedback calibration changed without a write");
   // Control byte moves only on its own write or on calibration
   a_ctrl_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!(wr_i && addr_i == `FEEDBACK_LOOP_CONTROL_OFS) && !cal_done_i)
      |=> $stable(ctrl_q))
      else $error("Control changed without a write");

   // Full-scale read returns the stored byte
   a_read_fs: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `FULL_SCALE_REFERENCE_OFS) |=> rdata_o == $past(fs_q))
      else $error("Full-scale read data wrong");
   // Clamp read returns the stored byte
   a_read_clamp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `OVERDRIVE_CLAMP_LEVEL_OFS) |=> rdata_o == $past(clamp_q))
      else $error("Clamp read data wrong");
   // Compensation read returns the stored byte
   a_read_comp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `LOSS_COMPENSATION_RESULT_OFS) |=> rdata_o == $past(comp_q))
      else $error("Compensation read data wrong");
   // Feedback calibration read returns the stored byte
   a_read_fbcal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `FEEDBACK_GAIN_CALIBRATION_OFS) |=> rdata_o == $past(fbcal_q))
      else $error("Feedback calibration read data wrong");
   // Read data falls back to zero when no read is pending
   a_read_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !rd_i |=> rdata_o == 8'h00)
      else $error("Read data stood without a read");
   // Reads outside the bank return zero
   a_read_unmapped: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && (addr_i < `FULL_SCALE_REFERENCE_OFS || addr_i > `FEEDBACK_LOOP_CONTROL_OFS))
      |=> rdata_o == 8'h00)
      else $error("Unmapped read returned data");

   // Every register shows its default at the first edge after reset
   a_reset_defaults: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $rose(reset_n_i) |-> (fs_q == `FULL_SCALE_REFERENCE_RST
         && clamp_q == `OVERDRIVE_CLAMP_LEVEL_RST
         && comp_q == `LOSS_COMPENSATION_RESULT_RST
         && fbcal_q == `FEEDBACK_GAIN_CALIBRATION_RST
         && ctrl_q == `FEEDBACK_LOOP_CONTROL_RST && rdata_o == 8'h00))
      else $error("Register left reset without its default");
endmodule

// ---- rtl/haptic_cal_map.svh ----
`ifndef HAPTIC_CAL_MAP_SVH
`define HAPTIC_CAL_MAP_SVH

// Register offsets (byte addresses on the plain port)
`define FULL_SCALE_REFERENCE_OFS      8'h1f
`define OVERDRIVE_CLAMP_LEVEL_OFS     8'h20
`define LOSS_COMPENSATION_RESULT_OFS  8'h21
`define FEEDBACK_GAIN_CALIBRATION_OFS 8'h22
`define FEEDBACK_LOOP_CONTROL_OFS     8'h23

// Reset values
`define FULL_SCALE_REFERENCE_RST      8'h3f
`define OVERDRIVE_CLAMP_LEVEL_RST     8'hff
`define LOSS_COMPENSATION_RESULT_RST  8'h0d
`define FEEDBACK_GAIN_CALIBRATION_RST 8'h6d
`define FEEDBACK_LOOP_CONTROL_RST     8'h36

// Control register field positions
`define NOISE_GATE_BIT                7
`define BRAKE_RATIO_MSB               6
`define BRAKE_RATIO_LSB               4
`define LOOP_GAIN_MSB                 3
`define LOOP_GAIN_LSB                 2
`define AMP_GAIN_MSB                  1
`define AMP_GAIN_LSB                  0

// Noise gate levels on the 8-bit scale where 8'hff is the supply
`define NOISE_GATE_LOW_LVL            8'h0a
`define NOISE_GATE_HIGH_LVL           8'h14

// Brake ratio code that removes feedback while braking
`define BRAKE_RATIO_OFF               3'h7

`endif

// ---- rtl/haptic_cal_pkg.sv ----
package haptic_cal_pkg;

   // Playback phase requested by the engine, one-hot
   typedef enum logic [3:0] {
      PH_IDLE      = 4'b0001,
      PH_DRIVE     = 4'b0010,
      PH_OVERDRIVE = 4'b0100,
      PH_BRAKE     = 4'b1000
   } drive_phase_t;

   // Feedback loop settling speed
   typedef enum logic [1:0] {
      LOOP_VERY_SLOW = 2'h0,
      LOOP_SLOW      = 2'h1,
      LOOP_FAST      = 2'h2,
      LOOP_VERY_FAST = 2'h3
   } loop_speed_t;

   // Decoded control byte
   typedef struct packed {
      logic        noise_gate_level;
      logic [2:0]  brake_gain_ratio;
      loop_speed_t loop_speed;
      logic [1:0]  back_emf_amp_gain;
   } loop_ctrl_t;

endpackage

// ---- rtl/shaper_cfg_if.sv ----
`timescale 1ns/1ps
// Configuration carried from the register bank to the output shaper
interface shaper_cfg_if;
   logic [7:0] full_scale;      // Full-scale reference level
   logic [7:0] clamp;           // Overdrive and brake ceiling
   logic [7:0] fb_cal;          // Feedback gain calibration value
   haptic_cal_pkg::loop_ctrl_t ctrl; // Control byte fields

   modport regs   (output full_scale, output clamp, output fb_cal, output ctrl);
   modport shaper (input full_scale, input clamp, input fb_cal, input ctrl);
endinterface

// ---- rtl/drive_shaper.sv ----
`timescale 1ns/1ps
`include "haptic_cal_map.svh"
module drive_shaper (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         reset_n_i,
   // Configuration
   shaper_cfg_if.shaper                      cfg,
   // Engine request
   input  wire haptic_cal_pkg::drive_phase_t phase_i,
   input  wire logic [7:0]                   req_mag_i,
   // Shaped outputs
   output logic [7:0]                        level_o,
   output logic [11:0]                       fb_gain_o,
   output haptic_cal_pkg::loop_speed_t       loop_speed_o
);
   import haptic_cal_pkg::*;

   // Brake-to-drive ratio for a code; code 7 yields zero
   function automatic logic [4:0] ratio_of(input logic [2:0] code);
      unique case (code)
         3'h0: ratio_of = 5'h01;
         3'h1: ratio_of = 5'h02;
         3'h2: ratio_of = 5'h03;
         3'h3: ratio_of = 5'h04;
         3'h4: ratio_of = 5'h06;
         3'h5: ratio_of = 5'h08;
         3'h6: ratio_of = 5'h10;
         3'h7: ratio_of = 5'h00;
      endcase
   endfunction

   // Gate level picked by the noise gate bit
   function automatic logic [7:0] gate_of(input logic sel);
      gate_of = sel ? `NOISE_GATE_HIGH_LVL : `NOISE_GATE_LOW_LVL;
   endfunction

   logic [7:0]  level_d;       // Next output level
   logic [11:0] fb_gain_d;     // Next feedback gain
   logic [15:0] scaled;        // Request times full scale
   logic [7:0]  boosted;       // Request limited by the clamp
   logic [12:0] brake_gain;    // Calibration times brake ratio

   // Level and gain for the current phase
   always_comb begin
      scaled     = 16'(req_mag_i) * 16'(cfg.full_scale);
      boosted    = (req_mag_i > cfg.clamp) ? cfg.clamp : req_mag_i;
      brake_gain = 13'(cfg.fb_cal) * 13'(ratio_of(cfg.ctrl.brake_gain_ratio));
      level_d    = 8'h00;
      fb_gain_d  = 12'h000;
      unique case (phase_i)
         PH_IDLE: begin
            level_d   = 8'h00;
            fb_gain_d = 12'h000;
         end
         PH_DRIVE: begin
            // Full request maps one code below a nonzero full-scale reference
            level_d   = scaled[15:8];
            fb_gain_d = 12'(cfg.fb_cal);
         end
         PH_OVERDRIVE: begin
            // Overdrive may pass full scale, never the clamp
            level_d   = boosted;
            fb_gain_d = 12'(cfg.fb_cal);
         end
         PH_BRAKE: begin
            // Disabled braking drives nothing at all
            if (cfg.ctrl.brake_gain_ratio == `BRAKE_RATIO_OFF) begin
               level_d   = 8'h00;
               fb_gain_d = 12'h000;
            end else begin
               level_d   = boosted;
               fb_gain_d = brake_gain[11:0];
            end
         end
         default: begin
            // Illegal phase codes are treated as idle
            level_d   = 8'h00;
            fb_gain_d = 12'h000;
         end
      endcase
      // Small requests are gated to silence to avoid idle buzz
      if (req_mag_i < gate_of(cfg.ctrl.noise_gate_level)) begin
         level_d = 8'h00;
      end
   end

   // Output registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         level_o      <= 8'h00;
         fb_gain_o    <= 12'h000;
         loop_speed_o <= LOOP_SLOW;
      end else begin
         level_o      <= level_d;
         fb_gain_o    <= fb_gain_d;
         loop_speed_o <= cfg.ctrl.loop_speed;
      end
   end

   a_clamp_ceiling: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (phase_i == PH_OVERDRIVE || phase_i == PH_BRAKE) |=> level_o <= $past(cfg.clamp))
      else $error("Overdrive or brake level above clamp");
   a_gate_silence: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (req_mag_i < gate_of(cfg.ctrl.noise_gate_level)) |=> level_o == 8'h00)
      else $error("Gated request produced output");
   a_brake_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (phase_i == PH_BRAKE && cfg.ctrl.brake_gain_ratio == `BRAKE_RATIO_OFF)
      |=> (fb_gain_o == 12'h000 && level_o == 8'h00))
      else $error("Disabled braking still drove");
   a_drive_gain: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      phase_i == PH_DRIVE |=> fb_gain_o == 12'($past(cfg.fb_cal)))
      else $error("Drive gain differs from calibration");
   a_brake_ratio: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (phase_i == PH_BRAKE && cfg.ctrl.brake_gain_ratio == 3'h6)
      |=> fb_gain_o == 12'({$past(cfg.fb_cal), 4'h0}))
      else $error("Brake ratio 16 not applied");
   a_drive_full_scale: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      phase_i == PH_DRIVE |=> level_o <= $past(cfg.full_scale))
      else $error("Drive level above full scale");
   a_loop_speed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $changed(cfg.ctrl.loop_speed) |=> loop_speed_o == $past(cfg.ctrl.loop_speed))
      else $error("Loop speed not forwarded");
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "haptic_cal_map.svh"
module testbench;
   import haptic_cal_pkg::*;

   // Clock, reset and register port
   logic         clk_i;
   logic         reset_n_i;
   logic [7:0]   addr_i;
   logic [7:0]   wdata_i;
   logic         wr_i;
   logic         rd_i;
   logic [7:0]   rdata_o;
   // Calibration result port
   logic         cal_done_i;
   logic [7:0]   cal_comp_i;
   logic [1:0]   cal_amp_gain_i;
   // Engine request and drive outputs
   drive_phase_t phase_i;
   logic [7:0]   req_mag_i;
   logic [7:0]   level_o;
   logic [11:0]  fb_gain_o;
   loop_speed_t  loop_speed_o;
   logic [1:0]   amp_gain_o;
   logic [7:0]   loss_comp_o;
   // Bookkeeping
   int           mismatches;
   int           n_tests;
   logic [7:0]   rst_v [5] = '{8'h3f, 8'hff, 8'h0d, 8'h6d, 8'h36}; // Table defaults
   logic [4:0]   ratio [7] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd6, 5'd8, 5'd16};

   haptic_closed_loop_cal_regs haptic_closed_loop_cal_regs_i (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cal_done_i(cal_done_i),
      .cal_comp_i(cal_comp_i), .cal_amp_gain_i(cal_amp_gain_i), .phase_i(phase_i),
      .req_mag_i(req_mag_i), .level_o(level_o), .fb_gain_o(fb_gain_o),
      .loop_speed_o(loop_speed_o), .amp_gain_o(amp_gain_o), .loss_comp_o(loss_comp_o));

   // Free-running 100 MHz clock
   always #5 clk_i = ~clk_i;

   // Single comparison point; four-state compare so unknowns never match
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Reset held for two clock edges
   task do_reset;
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
   endtask

   // One-cycle write strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // One-cycle read strobe; data sampled in the following cycle only
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   // Apply one engine request and judge the registered result a cycle later
   task drv(input drive_phase_t p, input logic [7:0] r, input logic [7:0] lv,
            input logic [11:0] g);
      @(posedge clk_i);
      phase_i <= p;
      req_mag_i <= r;
      @(posedge clk_i);
      #1 chk(level_o, lv);
      chk(fb_gain_o, g);
   endtask

   // Defaults after reset, unmapped read and idle read data
   task t_reset;
      logic [7:0] d;
      for (int i = 0; i < 5; i++) begin
         rd(8'(`FULL_SCALE_REFERENCE_OFS + i), d);
         chk(d, rst_v[i]);
      end
      chk(loop_speed_o, 2'h1);
      chk(amp_gain_o, 2'h2);
      chk(loss_comp_o, 8'h0d);
      rd(8'h1e, d);
      chk(d, 8'h00);
      @(posedge clk_i);
      #1 chk(rdata_o, 8'h00);
   endtask

   // Writes to all five registers hold, unmapped write ignored, second reset restores
   task t_rw;
      logic [7:0] d;
      for (int i = 0; i < 5; i++) wr(8'(`FULL_SCALE_REFERENCE_OFS + i), 8'(8'ha0 + i));
      wr(8'h24, 8'h5a);
      for (int i = 0; i < 5; i++) begin
         rd(8'(`FULL_SCALE_REFERENCE_OFS + i), d);
         chk(d, 12'(8'ha0 + i));
      end
      rd(8'h24, d);
      chk(d, 8'h00);
      do_reset();
      for (int i = 0; i < 5; i++) begin
         rd(8'(`FULL_SCALE_REFERENCE_OFS + i), d);
         chk(d, rst_v[i]);
      end
   endtask

   // Host setup, calibration writeback winning same-cycle writes, rerun after a change
   task t_cal;
      logic [7:0] d;
      wr(`FULL_SCALE_REFERENCE_OFS, 8'h50);
      wr(`FEEDBACK_LOOP_CONTROL_OFS, 8'h56);
      @(posedge clk_i);
      cal_done_i <= 1'b1;
      cal_comp_i <= 8'h22;
      cal_amp_gain_i <= 2'h1;
      wr_i <= 1'b1;
      addr_i <= `LOSS_COMPENSATION_RESULT_OFS;
      wdata_i <= 8'h99;
      @(posedge clk_i);
      cal_done_i <= 1'b0;
      wr_i <= 1'b0;
      #1 chk(loss_comp_o, 8'h22);
      chk(amp_gain_o, 2'h1);
      rd(`FEEDBACK_LOOP_CONTROL_OFS, d);
      chk(d, 8'h55);
      wr(`FEEDBACK_LOOP_CONTROL_OFS, 8'h37);
      #1 chk(amp_gain_o, 2'h3);
      wr(`FULL_SCALE_REFERENCE_OFS, 8'h3f);
      @(posedge clk_i);
      cal_done_i <= 1'b1;
      cal_comp_i <= 8'h1c;
      cal_amp_gain_i <= 2'h0;
      wr_i <= 1'b1;
      addr_i <= `FEEDBACK_LOOP_CONTROL_OFS;
      wdata_i <= 8'h36;
      @(posedge clk_i);
      cal_done_i <= 1'b0;
      wr_i <= 1'b0;
      #1 chk(loss_comp_o, 8'h1c);
      rd(`FEEDBACK_LOOP_CONTROL_OFS, d);
      chk(d, 8'h34);
      rd(`LOSS_COMPENSATION_RESULT_OFS, d);
      chk(d, 8'h1c);
   endtask

   // Closed-loop shaping: scaling, clamp, every brake ratio, loop speed, gate
   task t_shape;
      drv(PH_DRIVE, 8'h80, 8'h1f, 12'h06d);
      drv(PH_IDLE, 8'h80, 8'h00, 12'h000);
      wr(`FULL_SCALE_REFERENCE_OFS, 8'hff);
      wr(`OVERDRIVE_CLAMP_LEVEL_OFS, 8'h40);
      drv(PH_DRIVE, 8'h80, 8'h7f, 12'h06d);
      drv(PH_OVERDRIVE, 8'h90, 8'h40, 12'h06d);
      drv(PH_OVERDRIVE, 8'h30, 8'h30, 12'h06d);
      for (int c = 0; c < 8; c++) begin
         wr(`FEEDBACK_LOOP_CONTROL_OFS, {1'b0, c[2:0], c[1:0], 2'h2});
         if (c == 7) drv(PH_BRAKE, 8'h90, 8'h00, 12'h000);
         else drv(PH_BRAKE, 8'h90, 8'h40, 12'(8'h6d) * 12'(ratio[c]));
         chk(loop_speed_o, c[1:0]);
      end
      wr(`FEEDBACK_LOOP_CONTROL_OFS, 8'h36);
      drv(PH_OVERDRIVE, 8'h09, 8'h00, 12'h06d);
      drv(PH_OVERDRIVE, 8'h0a, 8'h0a, 12'h06d);
      wr(`FEEDBACK_LOOP_CONTROL_OFS, 8'hb6);
      drv(PH_OVERDRIVE, 8'h13, 8'h00, 12'h06d);
      drv(PH_OVERDRIVE, 8'h14, 8'h14, 12'h06d);
   endtask

   // Main sequence; inputs defined from time zero
   initial begin
      clk_i = 1'b0;
      reset_n_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      cal_done_i = 1'b0;
      cal_comp_i = 8'h00;
      cal_amp_gain_i = 2'h0;
      phase_i = PH_IDLE;
      req_mag_i = 8'h00;
      mismatches = 0;
      n_tests = 0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_rw();
      t_cal();
      t_shape();
      wrap_up();
   end

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule
